// >>> bench/shrp_host.sv
// Host model: serial master driving select, shift clock and data, capturing the answer.
`timescale 1ns/100ps
module shrp_host (
    input wire logic core_clk_in,
    input wire logic sdo_in,
    input wire logic sdo_oe_in,
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out
);
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b1;
    end
    task automatic set_cs(input logic v);
        @(posedge core_clk_in);
        cs_n_out <= v;
        // idle data line: a released line never keeps its last level.
        if (v) begin
            sdi_out <= ~sdi_out;
        end
    endtask : set_cs
    // byte shift: bits change with the falling clock, most significant first.
    task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx,
                         output logic [7:0] oe);
        rx = 8'h00;
        oe = 8'h00;
        @(posedge core_clk_in);
        sdi_out <= tx[7];
        for (int i = 7; i > 7 - nb; i--) begin
            repeat (4) @(posedge core_clk_in);
            sck_out <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            // Sampling just before the fall catches the bit that the port put out after the previous fall.
            rx[i] = sdo_in;
            oe[i] = sdo_oe_in;
            sck_out <= 1'b0;
            sdi_out <= (i > 0) ? tx[i-1] : ~tx[0];
        end
    endtask : shift
endmodule : shrp_host

// >>> bench/tb.sv
// Testbench: host model and reference sequence model against the serial host port.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, a); end end
module tb;
    import shrp_pkg::*;
    localparam logic [7:0] HL [8] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h41, 8'h45, 8'h49, 8'h4d};
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic ext_clr_n = 1'b1;
    logic irq_req = 1'b0;
    logic irq_pol = 1'b0;
    logic clk_en = 1'b1;
    logic fsel_exp = 1'b0;
    logic strap = 1'b1;
    logic e_irq, e_oe, cs_n, sck, sdi, sdo, sdo_oe, sel, wr, rd, fsel, fadv, irq, irq_oe;
    logic [7:0] radr, wdat, rdat;
    logic [7:0] regs [256];
    logic [7:0] exp_regs [256];
    logic [16:0] ev_q [$];
    int fifo_cnt = 0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    assign rdat = regs[radr];
    shrp_port shrp_port_inst (.core_clk_in(core_clk_in), .reset_in(reset_in), .clk_en_in(clk_en),
        .external_clear_n_in(ext_clr_n), .cs_n_in(cs_n), .shift_clk_in(sck),
        .serial_in_line_in(sdi), .serial_out_line_out(sdo), .serial_out_line_oe_out(sdo_oe),
        .host_port_sel_out(sel), .reg_addr_out(radr), .reg_wdata_out(wdat), .reg_wr_out(wr),
        .reg_rd_out(rd), .reg_rdata_in(rdat), .fifo_sel_out(fsel), .fifo_adv_out(fadv),
        .irq_req_in(irq_req), .irq_active_high_in(irq_pol), .irq_out(irq),
        .irq_oe_out(irq_oe));
    shrp_host shrp_host_inst (.core_clk_in(core_clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe),
        .cs_n_out(cs_n), .sck_out(sck), .sdi_out(sdi));
    always #12.5 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) begin
        cyc++;
        if (wr === 1'b1) begin
            ev_q.push_back({1'b1, radr, wdat});
            regs[radr] <= wdat;
        end
        if (rd === 1'b1) begin
            ev_q.push_back({1'b0, radr, 8'h00});
        end
        if (fadv === 1'b1) begin
            fifo_cnt++;
        end
        if (cyc > 1) begin
            `CHK("irq_out", e_irq, irq)
            `CHK("irq_oe", e_oe, irq_oe)
        end
        // A low clock enable must freeze the pin, so the model holds as well.
        if (reset_in) begin
            e_irq = 1'b0;
            e_oe = 1'b0;
        end else if (clk_en) begin
            e_irq = irq_pol & irq_req;
            e_oe = irq_pol | irq_req;
        end
        irq_req <= 1'($urandom);
        if (cyc % 300 == 0) begin
            irq_pol <= 1'($urandom);
        end
        if (cyc == 40000) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic frame(input logic [7:0] hdr, input logic [7:0] tx [$], input int nb_last);
        logic [16:0] exp_q [$];
        logic [7:0] out_d [int];
        logic [7:0] rxb, oeb, adr;
        logic [3:0] md;
        logic hv;
        int st, fexp, nb;
        md = hdr[3:0] & 4'hb;
        hv = strap && hdr[7:4] == HDR_TOP && md inside {4'h0, 4'h8, 4'h3, 4'h1, 4'h9};
        st = 0;
        fexp = 0;
        adr = 8'h00;
        for (int i = 0; i < tx.size() && hv; i++) begin
            if (i == tx.size() - 1 && nb_last < 8) break;
            if (st >= 4 && fsel_exp) fexp++;
            if (st == 0) begin
                adr = {hdr[2], tx[i][6:0]};
                fsel_exp = md == 4'h3 && (tx[i][6:0] <= 7'h1f || tx[i][6:0] == 7'h6a
                    || tx[i][6:0] == 7'h7a);
                st = md[0] ? 3 : 1;
                if (md == 4'h3) st = 4;
                if (tx[i][7]) begin
                    exp_q.push_back({1'b0, adr, 8'h00});
                    out_d[i + 1] = exp_regs[adr];
                    st = (md == 4'h3) ? 5 : md[3] ? 0 : 2;
                end
            end else if (st == 2) st = 0;
            else if (st == 5) begin
                exp_q.push_back({1'b0, adr, 8'h00});
                out_d[i + 1] = exp_regs[adr];
            end else begin
                exp_q.push_back({1'b1, adr, tx[i]});
                exp_regs[adr] = tx[i];
                if (st == 1) st = 0;
            end
        end
        ev_q.delete();
        fifo_cnt = 0;
        shrp_host_inst.set_cs(1'b0);
        shrp_host_inst.shift(hdr, 8, rxb, oeb);
        `CHK("oe in header", 8'h00, oeb)
        foreach (tx[i]) begin
            nb = (i == tx.size() - 1) ? nb_last : 8;
            shrp_host_inst.shift(tx[i], nb, rxb, oeb);
            if (out_d.exists(i)) begin
                `CHK("read byte", out_d[i], rxb)
                `CHK("oe in read", 8'hff, oeb)
            end else `CHK("oe idle", 8'h00, oeb)
        end
        repeat (4) @(posedge core_clk_in);
        shrp_host_inst.set_cs(1'b1);
        repeat (12) @(posedge core_clk_in);
        `CHK("events", exp_q.size(), ev_q.size())
        foreach (exp_q[k]) if (k < ev_q.size()) `CHK("event", exp_q[k], ev_q[k])
        `CHK("fifo steps", fexp, fifo_cnt)
        `CHK("fifo select", fsel_exp, fsel)
    endtask : frame
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] q [$];
        logic [7:0] al [5];
        void'($urandom(32'hd425d2c8));
        foreach (regs[i]) begin
            regs[i] = 8'($urandom);
            exp_regs[i] = regs[i];
        end
        repeat (2) @(posedge core_clk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        `CHK("strap default", 1'b1, sel)
        clk_en <= 1'b0;
        repeat (6) @(posedge core_clk_in);
        clk_en <= 1'b1;
        ext_clr_n <= 1'b0;
        shrp_host_inst.set_cs(1'b0);
        repeat (8) @(posedge core_clk_in);
        ext_clr_n <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        `CHK("strap low", 1'b0, sel)
        strap = 1'b0;
        q = {8'h01, 8'h5a};
        frame(8'h40, q, 8);
        ext_clr_n <= 1'b0;
        repeat (8) @(posedge core_clk_in);
        ext_clr_n <= 1'b1;
        repeat (8) @(posedge core_clk_in);
        `CHK("strap high", 1'b1, sel)
        strap = 1'b1;
        foreach (HL[h]) begin
            q = {8'h80 | 8'($urandom % 8), 8'h80 | 8'($urandom % 8), 8'h80 | 8'($urandom % 8),
                 8'($urandom), 8'($urandom % 8), 8'($urandom), 8'($urandom)};
            frame(HL[h], q, 8);
        end
        al = '{8'($urandom % 32), 8'h6a, 8'h7a, 8'h20, 8'h80 | 8'($urandom % 32)};
        foreach (al[a]) begin
            q = {al[a], 8'($urandom), 8'($urandom), 8'($urandom)};
            frame(8'h43, q, 8);
            frame(8'h47, q, 8);
        end
        q = {8'h01, 8'h33};
        frame(8'h42, q, 8);
        frame(8'hc0, q, 8);
        frame(8'h40, q, 5);
        frame(8'h40, q, 8);
        finish_test();
    end
endmodule : tb

// >>> core/shrp_pkg.sv
// Shared constants and types of the serial host register port.
package shrp_pkg;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_LAST = 3'h7;
    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam int SYNC_W = 4;
    localparam int SYNC_CS = 0;
    localparam int SYNC_SCK = 1;
    localparam int SYNC_SDI = 2;
    localparam int SYNC_CLR = 3;
    localparam logic [3:0] HDR_TOP = 4'h4;
    localparam int HDR_HALF_BIT = 2;
    localparam int HDR_INTL_BIT = 3;
    localparam int HDR_CONST_BIT = 1;
    localparam int HDR_RUN_BIT = 0;
    localparam int ADR_READ_BIT = 7;
    localparam logic [6:0] FIFO_LO = 7'h00;
    localparam logic [6:0] FIFO_HI = 7'h1f;
    localparam logic [6:0] FIFO_ALT0 = 7'h6a;
    localparam logic [6:0] FIFO_ALT1 = 7'h7a;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [6:0] {
        S_HDR = 7'h01,
        S_ADR = 7'h02,
        S_WDAT = 7'h04,
        S_RSLOT = 7'h08,
        S_WRUN = 7'h10,
        S_CRD = 7'h20,
        S_IGN = 7'h40
    } shrp_seq_e;
endpackage : shrp_pkg

// >>> core/shrp_port.sv
// Serial host register port: strap, framing, header decode, register strobes, interrupt pin.
// Notes on behaviour
// - Chip select level during external clear picks serial port or frame bus control.
// - Falling chip select starts a new session awaiting a header.
// - Input sampled on rising shift clock; output changes on falling shift clock.
// - Data moves in eight-bit groups, most significant bit first, both lines.
// - First byte after chip select falls is a header choosing the sequence.
// - Header bit two selects the lower or upper address half.
// - Headers 40/44: alternating address and data, read data in following slot.
// - Headers 48/4C: read data returned during the next address byte.
// - Headers 41/45: single reads, then one write address and a write run.
// - Headers 49/4D: interleaved reads, then one write address and a write run.
// - Interrupt output low active by default, high active selectable, any time.
// - Constant address mode: FIFO addresses hit current position, pointer advances per byte.
// - With header bit zero set, a write address ends the read phase; later bytes write that address.
`timescale 1ns/100ps
module shrp_port
    import shrp_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic external_clear_n_in,
    input wire logic cs_n_in,
    input wire logic shift_clk_in,
    input wire logic serial_in_line_in,
    output logic serial_out_line_out,
    output logic serial_out_line_oe_out,
    output logic host_port_sel_out,
    output logic [shrp_pkg::BYTE_W-1:0] reg_addr_out,
    output logic [shrp_pkg::BYTE_W-1:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    input wire logic [shrp_pkg::BYTE_W-1:0] reg_rdata_in,
    output logic fifo_sel_out,
    output logic fifo_adv_out,
    input wire logic irq_req_in,
    input wire logic irq_active_high_in,
    output logic irq_out,
    output logic irq_oe_out
);
    import shrp_pkg::*;

    typedef struct packed {
        shrp_seq_e st;
        logic strap;
        logic cs_d;
        logic sck_d;
        logic [BYTE_W-1:0] rx;
        logic [CNT_W-1:0] cnt;
        logic [BYTE_W-1:0] hdr;
        logic [BYTE_W-1:0] adr;
        logic fifo;
        logic rd_pend;
        logic tx_pend;
        logic [BYTE_W-1:0] tx;
        logic sdo;
        logic oe;
        logic rd;
        logic wr;
        logic adv;
        logic [BYTE_W-1:0] wdata;
        logic irq;
        logic irq_oe;
    } shrp_state_s;

    localparam shrp_state_s RST = '{st: S_HDR, strap: 1'b1, cs_d: 1'b1, sck_d: 1'b0,
        rx: BYTE_ZERO, cnt: CNT_ZERO, hdr: BYTE_ZERO, adr: BYTE_ZERO, fifo: 1'b0,
        rd_pend: 1'b0, tx_pend: 1'b0, tx: BYTE_ZERO, sdo: 1'b0, oe: 1'b0, rd: 1'b0,
        wr: 1'b0, adv: 1'b0, wdata: BYTE_ZERO, irq: 1'b0, irq_oe: 1'b0};

    shrp_state_s q;
    shrp_state_s n;
    logic [SYNC_W-1:0] pins;
    logic cs_s;
    logic sck_s;
    logic sdi_s;
    logic clr_s;
    logic active;
    logic rise;
    logic fall;
    logic byte_done;
    logic [BYTE_W-1:0] b;

    function automatic logic hdr_ok(input logic [BYTE_W-1:0] h);
        logic [1:0] lo;
        lo = h[1:0];
        if (h[7:4] != HDR_TOP) begin
            return 1'b0;
        end
        if (h[HDR_INTL_BIT]) begin
            return lo != 2'h2 && lo != 2'h3;
        end
        return lo != 2'h2;
    endfunction : hdr_ok

    ////////////////////////////////////////////////////////////////////////////////
    shrp_sync #(
        .WIDTH(SYNC_W),
        .INIT(4'hd)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .clk_en_in(clk_en_in),
        .async_in({external_clear_n_in, serial_in_line_in, shift_clk_in, cs_n_in}),
        .sync_out(pins)
    );

    assign cs_s = pins[SYNC_CS];
    assign sck_s = pins[SYNC_SCK];
    assign sdi_s = pins[SYNC_SDI];
    assign clr_s = pins[SYNC_CLR];
    assign active = clr_s && q.strap && !cs_s;
    assign rise = !q.sck_d && sck_s;
    assign fall = q.sck_d && !sck_s;
    assign byte_done = active && rise && (q.cnt == CNT_LAST);
    assign b = {q.rx[BYTE_W-2:0], sdi_s};

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = q;
        n.rd = 1'b0;
        n.wr = 1'b0;
        n.adv = 1'b0;
        n.cs_d = cs_s;
        n.sck_d = sck_s;
        n.irq = irq_active_high_in ? irq_req_in : 1'b0;
        n.irq_oe = irq_active_high_in ? 1'b1 : irq_req_in;
        if (!clr_s) begin
            n.strap = cs_s;
            n.st = S_HDR;
            n.cnt = CNT_ZERO;
            n.oe = 1'b0;
            n.tx_pend = 1'b0;
            n.rd_pend = 1'b0;
        end else if (!q.strap || cs_s) begin
            n.st = S_HDR;
            n.cnt = CNT_ZERO;
            n.oe = 1'b0;
            n.sdo = 1'b0;
            n.tx_pend = 1'b0;
            n.rd_pend = 1'b0;
        end else begin
            if (q.cs_d) begin
                n.st = S_HDR;
                n.cnt = CNT_ZERO;
            end
            if (q.rd_pend) begin
                n.tx = reg_rdata_in;
                n.tx_pend = 1'b1;
                n.rd_pend = 1'b0;
            end
            if (fall) begin
                if (q.cnt != CNT_ZERO) begin
                    n.sdo = q.tx[BYTE_W-1];
                    n.tx = {q.tx[BYTE_W-2:0], 1'b0};
                end else if (q.tx_pend) begin
                    n.sdo = q.tx[BYTE_W-1];
                    n.tx = {q.tx[BYTE_W-2:0], 1'b0};
                    n.tx_pend = 1'b0;
                    n.oe = 1'b1;
                end else begin
                    n.oe = 1'b0;
                    n.sdo = 1'b0;
                end
            end
            if (rise) begin
                n.rx = b;
                n.cnt = q.cnt + 3'h1;
            end
            if (byte_done) begin
                case (q.st)
                    S_HDR: begin
                        n.hdr = b;
                        n.st = hdr_ok(b) ? S_ADR : S_IGN;
                    end
                    S_ADR: begin
                        n.adr = {q.hdr[HDR_HALF_BIT], b[BYTE_W-2:0]};
                        n.fifo = q.hdr[HDR_CONST_BIT] && q.hdr[HDR_RUN_BIT]
                            && ((b[BYTE_W-2:0] >= FIFO_LO && b[BYTE_W-2:0] <= FIFO_HI)
                            || b[BYTE_W-2:0] == FIFO_ALT0 || b[BYTE_W-2:0] == FIFO_ALT1);
                        if (b[ADR_READ_BIT]) begin
                            n.rd = 1'b1;
                            n.rd_pend = 1'b1;
                            if (q.hdr[HDR_CONST_BIT]) begin
                                n.st = S_CRD;
                            end else if (q.hdr[HDR_INTL_BIT]) begin
                                n.st = S_ADR;
                            end else begin
                                n.st = S_RSLOT;
                            end
                        end else if (q.hdr[HDR_RUN_BIT]) begin
                            n.st = S_WRUN;
                        end else begin
                            n.st = S_WDAT;
                        end
                    end
                    S_RSLOT: begin
                        n.st = S_ADR;
                    end
                    S_WDAT: begin
                        n.wr = 1'b1;
                        n.wdata = b;
                        n.st = S_ADR;
                    end
                    S_WRUN: begin
                        n.wr = 1'b1;
                        n.wdata = b;
                        n.adv = q.fifo;
                    end
                    S_CRD: begin
                        n.adv = q.fifo;
                        n.rd = 1'b1;
                        n.rd_pend = 1'b1;
                    end
                    S_IGN: begin
                        n.st = S_IGN;
                    end
                    default: begin
                        n.st = S_HDR;
                    end
                endcase
            end
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            q <= RST;
        end else if (clk_en_in) begin
            q <= n;
        end
    end
    // Every output is a flop; read data is taken in the cycle reg_rd_out is high.
    assign serial_out_line_out = q.sdo;
    assign serial_out_line_oe_out = q.oe;
    assign host_port_sel_out = q.strap;
    assign reg_addr_out = q.adr;
    assign reg_wdata_out = q.wdata;
    assign reg_wr_out = q.wr;
    assign reg_rd_out = q.rd;
    assign fifo_sel_out = q.fifo;
    assign fifo_adv_out = q.adv;
    assign irq_out = q.irq;
    assign irq_oe_out = q.irq_oe;
    ////////////////////////////////////////////////////////////////////////////////
    chk_strap_sample: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && !clr_s |=> host_port_sel_out == $past(cs_s))
        else $error("strap not sampled from chip select");
    chk_cs_fall_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && clr_s && q.strap && q.cs_d && !cs_s |=> q.st == S_HDR && q.cnt == CNT_ZERO)
        else $error("session did not start at header");
    chk_rise_sample: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && active && !q.cs_d && rise |=> q.rx == {$past(q.rx[6:0]), $past(sdi_s)})
        else $error("input bit not shifted in on rising edge");
    chk_out_stable: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && active && !fall |=> $stable(serial_out_line_out))
        else $error("output changed outside falling edge");
    chk_cs_rise_end: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && clr_s && q.strap && cs_s |=> q.st == S_HDR && q.cnt == CNT_ZERO
        && !serial_out_line_oe_out)
        else $error("sequence not ended by chip select high");
    chk_half_addr: assert property (@(posedge core_clk_in) disable iff (reset_in)
        reg_rd_out || reg_wr_out |-> reg_addr_out[BYTE_W-1] == q.hdr[HDR_HALF_BIT])
        else $error("address half differs from header");
    chk_rslot_follow: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && byte_done && q.st == S_ADR && b[ADR_READ_BIT] && q.hdr == 8'h40
        |=> q.st == S_RSLOT ##1 q.tx_pend)
        else $error("non-interleaved read slot not prepared");
    chk_run_write: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && byte_done && q.st == S_WRUN |=> reg_wr_out && reg_wdata_out == $past(b))
        else $error("write run byte not written");
    chk_irq_low: assert property (@(posedge core_clk_in) disable iff (reset_in)
        clk_en_in && !irq_active_high_in |=> !irq_out && irq_oe_out == $past(irq_req_in))
        else $error("low active interrupt drive wrong");
endmodule : shrp_port

// >>> core/shrp_sync.sv
// Three-stage input synchroniser with agreement filter, one lane per bit.
`timescale 1ns/100ps
module shrp_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    if (WIDTH < 1) begin : g_bad_width
        $error("shrp_sync: WIDTH must be at least one");
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic f_q;
            always_ff @(posedge core_clk_in) begin
                if (reset_in) begin
                    s1_q <= INIT[i];
                    s2_q <= INIT[i];
                    s3_q <= INIT[i];
                    f_q <= INIT[i];
                end else if (clk_en_in) begin
                    s1_q <= async_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // A change counts only once stages two and three agree.
                    if (s2_q == s3_q) begin
                        f_q <= s3_q;
                    end
                end
            end
            assign sync_out[i] = f_q;
        end
    endgenerate
endmodule : shrp_sync
